// File: hdl/pslp_params.svh
`ifndef PSLP_PARAMS_SVH
`define PSLP_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PSLP_CTRL_OFS      8'h00
`define PSLP_BLK_OFS       8'h04
`define PSLP_VOLT_OFS      8'h08
`define PSLP_STAT_OFS      8'h0C

// ****************************************************************
// control register fields
// ****************************************************************
`define PSLP_CTRL_PL_BLOCK 0
`define PSLP_CTRL_SKIP     1
`define PSLP_CTRL_SOF_EN   2
`define PSLP_CTRL_DIR_LSB  3

// ****************************************************************
// reset values
// ****************************************************************
`define PSLP_CTRL_RST      6'h00
`define PSLP_BLK_RST       10'h000
`define PSLP_VOLT_RST      8'h73

// ****************************************************************
// voltage threshold and timing
// ****************************************************************
`define PSLP_V1_PCT        24'd75
`define PSLP_PCT_DEN       24'd100
`define PSLP_CLK_HZ        200000000
`define PSLP_MS_PER_S      1000
`define PSLP_TL1_MS        16'd25
`define PSLP_TL2_MS        16'd150
`define PSLP_TL3_MS        16'd45
`define PSLP_FUSE_MS       16'd50

`endif

// File: hdl/pslp_pkg.sv
package pslp_pkg;

  // ****************************************************************
  // detector inputs from the measuring functions
  // ****************************************************************
  typedef struct packed {
    logic [15:0] v1_mag;        // positive-sequence voltage magnitude, volts
    logic        load_cur;      // load-current detector operated
    logic        fault_det;     // fault detector operated
    logic        open_pole;     // open-pole detection, one or more poles open
    logic        pos_seq_oc;    // positive-sequence overcurrent detector
    logic [2:0]  z2_ph;         // zone 2 phase elements ab, bc, ca
    logic        z2_gnd;        // any zone 2 ground element
    logic        trip;          // any trip issued by the relay
    logic        swing;         // out-of-step condition present
    logic        gnd_inst_trip; // ground instantaneous overcurrent trip
    logic        z2_time_trip;  // zone 2 time-delayed trip
    logic        z3_time_trip;  // zone 3 time-delayed trip
    logic        z4_time_trip;  // zone 4 time-delayed trip
    logic        z1_ph_trip;    // zone 1 instantaneous phase trip
    logic        ext_trip;      // configurable trip from contact input
  } pslp_det_type;

  // ****************************************************************
  // block, trip and reclose outputs
  // ****************************************************************
  typedef struct packed {
    logic       dist_block;     // distance tripping blocked
    logic       dir_block;      // directional tripping blocked
    logic [2:0] backup_block;   // phase inst, ground inst, ground toc
    logic       potential_loss; // potential loss declared
    logic       reclose_init;   // reclose initiate
    logic       reclose_cancel; // reclose cancel
    logic       lp_enabled;     // line pickup armed
    logic       lp_trip;        // line pickup trip
  } pslp_out_type;

  // ****************************************************************
  // complete state of the block
  // ****************************************************************
  typedef struct packed {
    logic [17:0]  pre;          // millisecond prescaler
    logic [5:0]   ctrl;         // settings
    logic [9:0]   blk;          // reclose block selectors
    logic [7:0]   volt;         // rated per-unit voltage
    logic         wr_pend;      // write data phase pending
    logic [7:0]   addr;         // latched address
    logic [31:0]  rdata;        // read data
    logic         v1_up;        // registered voltage detector
    logic [15:0]  fuse_cnt;     // potential-loss delay timer
    logic [15:0]  tl1_cnt;      // energised-line timer
    logic [15:0]  tl2_cnt;      // dead-line enable timer
    logic [15:0]  tl3_cnt;      // security delay timer
    pslp_out_type out;          // registered outputs
  } pslp_state_type;

endpackage : pslp_pkg

// File: hdl/pslp_top.sv
// The AHB-Lite slave port and the address map were chosen for this implementation.
`include "pslp_params.svh"

module pslp_top #(
  parameter int          CYC_PER_MS = `PSLP_CLK_HZ / `PSLP_MS_PER_S, // cycles per ms tick
  parameter logic [15:0] FUSE_MS    = `PSLP_FUSE_MS                  // potential-loss delay, ms
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire pslp_pkg::pslp_det_type det,
  output pslp_pkg::pslp_out_type     outs
);

  // ****************************************************************
  // state and combinational helpers
  // ****************************************************************
  pslp_pkg::pslp_state_type s;        // registered state
  pslp_pkg::pslp_state_type nxt_s;    // next state
  logic        v1_up;                 // voltage detector picked up
  logic        tick;                  // one-cycle millisecond tick
  logic        arm;                   // potential-loss arming gate
  logic        fuse_done;             // potential-loss delay expired
  logic        pl_next;               // next potential-loss value
  logic        dead;                  // open breaker, line dead
  logic        tl1_done;              // energised-line timer expired
  logic        lp_en;                 // line pickup enabled
  logic        lp_req;                // line pickup trip request
  logic        tl3_done;              // security delay expired
  logic [8:0]  rc_src;                // reclose block sources
  logic [8:0]  rc_sel;                // effective selectors
  logic        rc_block;              // any selected source blocks reclose
  logic        pot_block;             // potential blocking active
  logic [17:0] pre_last;              // last prescaler count

  assign pre_last  = 18'(CYC_PER_MS - 1);
  assign hreadyout = ce;              // stall the bus while frozen
  assign hresp     = 1'b0;            // always okay
  assign hrdata    = s.rdata;
  assign outs      = s.out;

  // ****************************************************************
  // pickup timer step, saturates at target, clears when idle
  // ****************************************************************
  function automatic logic [15:0] tmr_step(
    input logic        run,
    input logic [15:0] cnt,
    input logic [15:0] tgt,
    input logic        tk
  );
    logic [15:0] res;
    res = 16'h0000;
    if (!run) begin
      res = 16'h0000;
    end else if (cnt >= tgt) begin
      res = cnt;
    end else begin
      res = cnt + {15'h0000, tk};
    end
    return res;
  endfunction : tmr_step

  // ****************************************************************
  // read multiplexer, unmapped addresses read zero
  // ****************************************************************
  function automatic logic [31:0] rd_mux(
    input logic [7:0]              a,
    input pslp_pkg::pslp_state_type st
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `PSLP_CTRL_OFS: begin
        r = {26'h0000000, st.ctrl};
      end
      `PSLP_BLK_OFS: begin
        r = {22'h000000, st.blk};
      end
      `PSLP_VOLT_OFS: begin
        r = {24'h000000, st.volt};
      end
      `PSLP_STAT_OFS: begin
        r = {27'h0000000, st.out.lp_trip, st.out.lp_enabled, st.out.reclose_cancel,
             st.out.reclose_init, st.out.potential_loss};
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction : rd_mux

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    nxt_s = s;
    // fixed 75 percent threshold against the rated setting
    v1_up = ({8'h00, det.v1_mag} * `PSLP_PCT_DEN) >=
            ({16'h0000, s.volt} * `PSLP_V1_PCT);
    nxt_s.v1_up = v1_up;

    // millisecond time base
    tick = (s.pre == pre_last);
    nxt_s.pre = tick ? 18'h00000 : s.pre + 18'h00001;

    // bus write data phase
    if (s.wr_pend) begin
      case (s.addr)
        `PSLP_CTRL_OFS: begin
          nxt_s.ctrl = hwdata[5:0];
        end
        `PSLP_BLK_OFS: begin
          nxt_s.blk = hwdata[9:0];
        end
        `PSLP_VOLT_OFS: begin
          nxt_s.volt = hwdata[7:0];
        end
        default: begin
          nxt_s.ctrl = s.ctrl;                          // unmapped or read-only
        end
      endcase
    end
    // bus address phase
    nxt_s.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      nxt_s.addr    = haddr[7:0];
      nxt_s.wr_pend = hwrite;
      if (!hwrite) begin
        nxt_s.rdata = (haddr[31:8] == 24'h000000) ? rd_mux(haddr[7:0], s) : 32'h0000_0000;
      end
    end else begin
      nxt_s.addr = s.addr;
    end

    // potential-loss detection
    arm = !v1_up && det.load_cur && !det.fault_det && !det.open_pole;
    nxt_s.fuse_cnt = tmr_step(arm, s.fuse_cnt, FUSE_MS, tick);
    fuse_done = arm && (s.fuse_cnt >= FUSE_MS);
    // seal-in while voltage stays low, open poles kill it
    pl_next = !det.open_pole &&
              (fuse_done || (s.out.potential_loss && !v1_up));
    nxt_s.out.potential_loss = pl_next;
    pot_block = pl_next && s.ctrl[`PSLP_CTRL_PL_BLOCK];
    nxt_s.out.dist_block = pot_block;
    nxt_s.out.dir_block  = pot_block;
    // backup overcurrent blocked only when directionally controlled
    nxt_s.out.backup_block = {3{pot_block}} &
                             s.ctrl[`PSLP_CTRL_DIR_LSB +: 3];

    // reclose block sources, bit i pairs with selector i+1
    rc_src = {det.ext_trip,
              det.trip && (|det.z2_ph),
              det.z1_ph_trip,
              det.z4_time_trip,
              det.z3_time_trip,
              det.z2_time_trip,
              det.gnd_inst_trip,
              det.trip && (&det.z2_ph),
              det.trip && det.swing};
    rc_sel   = s.blk[9:1] | {9{s.blk[0]}};
    rc_block = |(rc_src & rc_sel);
    nxt_s.out.reclose_cancel = rc_block;
    nxt_s.out.reclose_init   = det.trip && !rc_block;

    // line pickup
    dead = !det.load_cur && !v1_up;
    nxt_s.tl1_cnt = tmr_step(v1_up, s.tl1_cnt, `PSLP_TL1_MS, tick);
    tl1_done = v1_up && (s.tl1_cnt >= `PSLP_TL1_MS);
    if (tl1_done) begin
      nxt_s.tl2_cnt = 16'h0000;
    end else if (s.tl2_cnt >= `PSLP_TL2_MS) begin
      nxt_s.tl2_cnt = s.tl2_cnt;                                     // held until fast reset
    end else begin
      nxt_s.tl2_cnt = tmr_step(dead, s.tl2_cnt, `PSLP_TL2_MS, tick);
    end
    lp_en = s.ctrl[`PSLP_CTRL_SOF_EN] && !tl1_done &&
            (s.tl2_cnt >= `PSLP_TL2_MS);
    lp_req = lp_en && (det.pos_seq_oc || (|det.z2_ph) || det.z2_gnd);
    nxt_s.tl3_cnt = tmr_step(lp_req, s.tl3_cnt, `PSLP_TL3_MS, tick);
    tl3_done = lp_req && (s.tl3_cnt >= `PSLP_TL3_MS);
    nxt_s.out.lp_enabled = lp_en;
    nxt_s.out.lp_trip = lp_req && (s.ctrl[`PSLP_CTRL_SKIP] || tl3_done);
  end

  // ****************************************************************
  // state register, frozen while the clock enable is low
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s      <= '0;
      s.ctrl <= `PSLP_CTRL_RST;
      s.blk  <= `PSLP_BLK_RST;
      s.volt <= `PSLP_VOLT_RST;
    end else if (ce) begin
      s <= nxt_s;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [23:0] v1_lhs;                // helper: scaled voltage
  logic [23:0] v1_rhs;                // helper: scaled threshold
  assign v1_lhs = {8'h00, det.v1_mag} * `PSLP_PCT_DEN;
  assign v1_rhs = {16'h0000, s.volt} * `PSLP_V1_PCT;

  sequence seal_cond_s;
    ce && s.out.potential_loss && !v1_up && !det.open_pole;
  endsequence

  sequence loss_held_s;
    s.out.potential_loss;
  endsequence

  pl_block_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s.out.dist_block == (s.out.potential_loss && $past(s.ctrl[`PSLP_CTRL_PL_BLOCK])))
    else $error("distance block does not follow potential loss and setting");

  dir_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s.out.dir_block == s.out.dist_block)
    else $error("directional block differs from distance block");

  v1_threshold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> s.v1_up == $past(v1_lhs >= v1_rhs))
    else $error("voltage detector not at 75 percent of rating");

  fault_inhibit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && det.fault_det |=> s.fuse_cnt == 16'h0000)
    else $error("loss timer runs during a fault");

  open_pole_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && det.open_pole |=> !s.out.potential_loss)
    else $error("potential loss present with open pole");

  pl_seal_a: assert property (@(posedge hclk) disable iff (!hresetn)
    seal_cond_s |=> loss_held_s)
    else $error("potential loss did not seal in");

  pl_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && v1_up && s.out.potential_loss |=> !s.out.potential_loss)
    else $error("potential loss did not release on voltage return");

  pl_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !s.out.potential_loss ##1 s.out.potential_loss |->
    $past(s.fuse_cnt) >= FUSE_MS)
    else $error("potential loss without expired delay");

  master_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && s.blk[0] && det.gnd_inst_trip && det.trip |=>
    s.out.reclose_cancel && !s.out.reclose_init)
    else $error("master selector did not block reclose");

  rc_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && s.blk == 10'h000 && det.trip |=> s.out.reclose_init && !s.out.reclose_cancel)
    else $error("reclose blocked with no selector set");

  sof_disable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(s.ctrl[`PSLP_CTRL_SOF_EN]) |-> !s.out.lp_trip && !s.out.lp_enabled)
    else $error("line pickup active while disabled");

  bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && lp_en && s.ctrl[`PSLP_CTRL_SKIP] && det.pos_seq_oc |=> s.out.lp_trip)
    else $error("bypassed line pickup did not trip at once");

  delay_trip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !s.ctrl[`PSLP_CTRL_SKIP] && !s.out.lp_trip ##1 s.out.lp_trip |->
    $past(s.tl3_cnt) >= `PSLP_TL3_MS)
    else $error("line pickup tripped before 45 ms");

  enable_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s.out.lp_enabled |-> $past(s.tl2_cnt) >= `PSLP_TL2_MS)
    else $error("line pickup enabled before 150 ms");

  fast_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && v1_up && s.tl1_cnt >= `PSLP_TL1_MS |=> s.tl2_cnt == 16'h0000 && !s.out.lp_enabled)
    else $error("enable timer not fast-reset after 25 ms");

  // ****************************************************************
  // arming gate and backup assertions
  // ****************************************************************
  // voltage up or no load keeps the timer clear
  arm_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (v1_up || !det.load_cur) |=> s.fuse_cnt == 16'h0000)
    else $error("loss timer runs without arming");

  // non-directional backup is never blocked
  backup_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.out.backup_block & ~$past(s.ctrl[`PSLP_CTRL_DIR_LSB +: 3])) == 3'h0)
    else $error("non-directional backup blocked");

  // ****************************************************************
  // reclose and line pickup assertions
  // ****************************************************************
  // cancel raised, initiate withheld
  sequence rc_blocked_s;
    s.out.reclose_cancel && !s.out.reclose_init;
  endsequence

  // out-of-step trip
  swing_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && s.blk[1] && det.trip && det.swing |=> rc_blocked_s)
    else $error("out-of-step trip kept reclose");

  // all three zone 2 phase pairs
  three_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && s.blk[2] && det.trip && (&det.z2_ph) |=> rc_blocked_s)
    else $error("three-phase fault kept reclose");

  // ground instantaneous trip
  gnd_inst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && s.blk[3] && det.gnd_inst_trip |=> rc_blocked_s)
    else $error("ground instantaneous trip kept reclose");

  // delayed zone trips, own selectors
  zone_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && ((s.blk[4] && det.z2_time_trip) || (s.blk[5] && det.z3_time_trip) ||
           (s.blk[6] && det.z4_time_trip)) |=> rc_blocked_s)
    else $error("delayed zone trip kept reclose");

  // zone 1 phase, or any zone 2 phase in a trip
  zone_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && ((s.blk[7] && det.z1_ph_trip) || (s.blk[8] && det.trip && (|det.z2_ph))) |=>
    rc_blocked_s)
    else $error("phase zone trip kept reclose");

  // external contact trip
  ext_trip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && s.blk[9] && det.ext_trip |=> rc_blocked_s)
    else $error("external trip kept reclose");

  // zone 2 element alone, delay bypassed
  zone_two_trip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && lp_en && s.ctrl[`PSLP_CTRL_SKIP] && ((|det.z2_ph) || det.z2_gnd) |=>
    s.out.lp_trip)
    else $error("zone 2 request did not trip");

  // no pickup trip outside the armed window
  lp_armed_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !lp_en |=> !s.out.lp_trip)
    else $error("pickup trip while not armed");

endmodule : pslp_top

// File: testbench/pslp_meas_model.sv
// ****************************************************************
// measuring functions seen from the supervision block
// ****************************************************************
module pslp_meas_model (
  input  wire logic [15:0]       v1,
  input  wire logic              load,
  input  wire logic              fault,
  input  wire logic              open_pole,
  input  wire logic [9:0]        src,
  output pslp_pkg::pslp_det_type det
);
  timeunit 1ns;
  timeprecision 100ps;
  // detector levels follow the line state with no delay
  always_comb begin
    det               = '0;
    det.v1_mag        = v1;
    det.load_cur      = load;
    det.open_pole     = open_pole;
    det.fault_det     = fault;             // a real fault always operates fd
    det.pos_seq_oc    = fault;             // bolted fault current
    det.z2_gnd        = fault;
    det.z2_ph         = (fault || src[2]) ? 3'h7 : {2'h0, src[8]};
    det.trip          = |src;              // any source is also a relay trip
    det.swing         = src[1];
    det.gnd_inst_trip = src[3];
    det.z2_time_trip  = src[4];
    det.z3_time_trip  = src[5];
    det.z4_time_trip  = src[6];
    det.z1_ph_trip    = src[7];
    det.ext_trip      = src[9];
  end
endmodule : pslp_meas_model

// File: testbench/tb_potential_supervision_line_pickup.sv
`include "pslp_params.svh"
module tb_potential_supervision_line_pickup;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int MS  = 4;                  // cycles per ms tick, shortened
  localparam int PL  = 4;                  // bit positions inside outs
  localparam int RI  = 3;
  localparam int RC  = 2;
  localparam int LPE = 1;
  localparam int LPT = 0;
  logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic                   load, fault, open_pole, ce;
  logic [31:0]            haddr, hwdata, hrdata;
  logic [1:0]             htrans;
  logic [15:0]            v1;
  logic [9:0]             src;
  pslp_pkg::pslp_det_type det;
  pslp_pkg::pslp_out_type outs;
  int                     fails, samples_checked;

  pslp_top #(.CYC_PER_MS(MS), .FUSE_MS(16'h0003)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .det(det), .outs(outs));
  pslp_meas_model i_meas (.v1(v1), .load(load), .fault(fault),
    .open_pole(open_pole), .src(src), .det(det));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_sim();
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // one bus phase, bounded wait for hready
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic wait_bit(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[k] !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk_bit(outs[k], v, "output late");
  endtask : wait_bit

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    chk_word(hrdata, exp);
    chk_bit(hresp, 1'b0, "response not okay");
  endtask : rd_chk

  // ****************************************************************
  // clock, watchdog and sequence
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // cuts a hang short
  initial begin
    repeat (100000) @(posedge hclk);
    fails++;
    end_sim();
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    {fault, open_pole, src, fails, samples_checked} = '0;
    ce   = 1'b1;
    v1   = 16'h0073;                       // healthy line, loaded
    load = 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // register map, unmapped and read-only places
    rd_chk(`PSLP_CTRL_OFS, 32'h0);
    rd_chk(`PSLP_BLK_OFS, 32'h0);
    rd_chk(`PSLP_VOLT_OFS, 32'h73);
    bus_wr(`PSLP_VOLT_OFS, 32'hFFFFFF64);
    rd_chk(`PSLP_VOLT_OFS, 32'h64);
    bus_wr(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h0);
    bus_wr(`PSLP_STAT_OFS, 32'h1F);
    rd_chk(`PSLP_STAT_OFS, 32'h0);
    bus_wr(`PSLP_VOLT_OFS, 32'h73);
    // potential lost with load, blocking on, ground inst directional
    bus_wr(`PSLP_CTRL_OFS, 32'h11);
    v1 <= 16'h0000;
    cyc(2 * MS);
    chk_bit(outs[PL], 1'b0, "loss too early");
    wait_bit(PL, 1'b1, 4 * MS);
    chk_bit(outs.dist_block, 1'b1, "distance free");
    chk_bit(outs.dir_block, 1'b1, "directional free");
    chk_word({29'h0, outs.backup_block}, 32'h2);
    rd_chk(`PSLP_STAT_OFS, 32'h1);
    ce <= 1'b0;                            // frozen while the voltage returns
    v1 <= 16'h0073;
    cyc(3);
    chk_bit(outs[PL], 1'b1, "state not frozen");
    chk_bit(hreadyout, 1'b0, "bus not stalled");
    ce <= 1'b1;
    v1   <= 16'h0056;                      // just under the 75 percent level
    load <= 1'b0;
    cyc(6 * MS);
    chk_bit(outs[PL], 1'b1, "seal lost");
    v1 <= 16'h0057;                        // just over the 75 percent level
    wait_bit(PL, 1'b0, 4);
    // blocking setting off
    bus_wr(`PSLP_CTRL_OFS, 32'h0);
    v1   <= 16'h0000;
    load <= 1'b1;
    wait_bit(PL, 1'b1, 5 * MS);
    chk_bit(outs.dist_block, 1'b0, "blocked with setting no");
    chk_bit(outs.dir_block, 1'b0, "blocked with setting no");
    v1 <= 16'h0073;
    wait_bit(PL, 1'b0, 4);
    // fault and open pole keep the loss away
    fault <= 1'b1;
    v1    <= 16'h0000;
    cyc(6 * MS);
    chk_bit(outs[PL], 1'b0, "loss on fault");
    fault     <= 1'b0;
    open_pole <= 1'b1;
    cyc(6 * MS);
    chk_bit(outs[PL], 1'b0, "loss with pole open");
    open_pole <= 1'b0;
    v1        <= 16'h0073;
    // each selector against its own source, then a plain trip
    for (int i = 1; i < 10; i++) begin
      bus_wr(`PSLP_BLK_OFS, 32'h1 << i);
      src <= 10'h001 | (10'h001 << i);
      cyc(2);
      chk_bit(outs[RC], 1'b1, "cancel missing");
      chk_bit(outs[RI], 1'b0, "initiate kept");
      src <= 10'h001;
      cyc(2);
      chk_bit(outs[RI], 1'b1, "initiate missing");
      chk_bit(outs[RC], 1'b0, "cancel unselected");
      src <= 10'h000;
    end
    // master selector covers every source
    bus_wr(`PSLP_BLK_OFS, 32'h1);
    for (int i = 1; i < 10; i++) begin
      src <= 10'h001 | (10'h001 << i);
      cyc(2);
      chk_bit(outs[RC], 1'b1, "master no cancel");
    end
    // one zone 2 phase is not a three-phase fault
    bus_wr(`PSLP_BLK_OFS, 32'h4);
    src <= 10'h101;
    cyc(2);
    chk_bit(outs[RC], 1'b0, "partial three-phase");
    src <= 10'h000;
    // line pickup with security delay
    bus_wr(`PSLP_BLK_OFS, 32'h0);
    bus_wr(`PSLP_CTRL_OFS, 32'h4);
    v1   <= 16'h0000;
    load <= 1'b0;
    cyc(148 * MS);
    chk_bit(outs[LPE], 1'b0, "pickup armed early");
    wait_bit(LPE, 1'b1, 4 * MS);
    fault <= 1'b1;
    cyc(43 * MS);
    chk_bit(outs[LPT], 1'b0, "pickup trip early");
    wait_bit(LPT, 1'b1, 4 * MS);
    fault <= 1'b0;
    wait_bit(LPT, 1'b0, 4);
    // bypassed delay, zone 2 phase element alone
    bus_wr(`PSLP_CTRL_OFS, 32'h6);
    src <= 10'h100;
    cyc(2);
    chk_bit(outs[LPT], 1'b1, "bypass not immediate");
    src <= 10'h000;
    cyc(2);
    chk_bit(outs[LPT], 1'b0, "trip stuck");
    // energised line takes pickup out of service
    v1 <= 16'h0073;
    cyc(23 * MS);
    chk_bit(outs[LPE], 1'b1, "disarmed early");
    wait_bit(LPE, 1'b0, 4 * MS);
    // function switched off
    bus_wr(`PSLP_CTRL_OFS, 32'h2);
    v1 <= 16'h0000;
    cyc(155 * MS);
    fault <= 1'b1;
    cyc(3);
    chk_bit(outs[LPT], 1'b0, "trip while disabled");
    chk_bit(outs[LPE], 1'b0, "armed while disabled");
    end_sim();
  end
endmodule : tb_potential_supervision_line_pickup
